//--- srp_ctl.sv
// host-side refresh, self refresh, power-down and clock suspend controller
`timescale 1ns/1ns
`default_nettype none
`include "srp_params.svh"

// Notes on behaviour
// - issue one refresh command per refresh
// - precharge all open banks before refresh
// - wait precharge period before refresh
// - only nop during refresh cycle time
// - single refreshes spaced interval over rows
// - burst of refreshes per interval allowed
// - self refresh entry keeps gate low
// - stay in self refresh row active time
// - stable clock, gate high, nops exit time
// - resume distributed refresh after self refresh
// - leave power-down within refresh period
// - power-down exit is nop with gate high
// - refreshes may interleave with other traffic
// - precharge select bit high closes all
module srp_ctl #(
   parameter int ADDR_W = `SRP_ADDR_W,
   parameter int ROW_CYC = `SRP_ROW_CYC
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic usr_valid,
   input wire srp_pkg::srp_cmd_t usr_cmd,
   input wire logic [ADDR_W-1:0] usr_addr,
   input wire logic [1:0] usr_ba,
   output logic usr_ready,
   input wire logic sr_req,
   input wire logic pd_req,
   input wire logic susp_req,
   output logic sd_clk_run,
   output logic sd_cke,
   output logic sd_cs_n,
   output logic sd_ras_n,
   output logic sd_cas_n,
   output logic sd_we_n,
   output logic [ADDR_W-1:0] sd_addr,
   output logic [1:0] sd_ba,
   output logic st_self_refresh,
   output logic st_power_down,
   output logic st_pd_active
);
   import srp_pkg::*;

   localparam int BW = 8; // width of short wait counter
   localparam int TW = 16; // width of interval timer

   // ****************************************************
   // state
   // ****************************************************
   srp_state_t state_reg; // controller state
   srp_cmd_t cmd_reg; // command on the pins
   logic [ADDR_W-1:0] addr_reg; // address pins
   logic [1:0] ba_reg; // bank pins
   logic cke_reg; // clock gate pin
   logic clk_run_reg; // clock running request
   logic [BW-1:0] busy_reg; // cycles left of current wait
   logic [`SRP_BANKS-1:0] open_reg; // banks with an open row
   logic ref_pend_reg; // refresh owed
   logic ready_reg; // user command may be taken
   logic sr_st_reg; // in self refresh
   logic pd_st_reg; // in power-down
   logic pd_act_reg; // power-down with an open row
   logic take; // user command taken this edge
   logic iv_done; // refresh spacing elapsed
   logic iv_load; // reload spacing timer
   logic quiet; // nothing issued last cycle, no wait left

   assign take = usr_valid && ready_reg;
   assign quiet = (cmd_reg == CMD_NOP) && (busy_reg == '0);
   // restart spacing at each tick and on self refresh exit
   // distributed rate again after exit
   assign iv_load = iv_done || ((state_reg == ST_XSR) && (busy_reg == '0));

   // ****************************************************
   // refresh spacing
   // ****************************************************
   // one refresh owed per interval over rows
   // burst alternative unused, single spacing kept
   srp_timer #(.W(TW)) u_interval (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .load(iv_load),
      .load_val(TW'(ROW_CYC - 1)),
      .done(iv_done)
   );

   // pending flag: set wins over clear
   // each owed refresh issued once
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ref_pend_reg <= 1'b0;
      end else begin
         ref_pend_reg <= iv_done || (ref_pend_reg && (cmd_reg != CMD_REF));
      end
   end

   // ****************************************************
   // command sequencer
   // ****************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cmd_reg <= CMD_INH;
         addr_reg <= '0;
         ba_reg <= '0;
         cke_reg <= `SRP_CKE_RST;
         clk_run_reg <= 1'b1;
         busy_reg <= '0;
      end else begin
         // nop unless a branch issues something
         cmd_reg <= CMD_NOP;
         if (busy_reg != '0) begin
            busy_reg <= busy_reg - 1'b1;
         end
         unique case (state_reg)
            ST_IDLE: begin
               cke_reg <= 1'b1;
               if (take) begin
                  cmd_reg <= usr_cmd;
                  addr_reg <= usr_addr;
                  ba_reg <= usr_ba;
                  if (usr_cmd == CMD_PRE) begin
                     busy_reg <= BW'(`SRP_RP_CYC - 1);
                  end
               end else if ((ref_pend_reg || sr_req) && quiet) begin
                  if (open_reg != '0) begin
                     // select bit high means all banks
                     cmd_reg <= CMD_PRE;
                     addr_reg <= ADDR_W'(1) << `SRP_PRE_SEL_BIT;
                     busy_reg <= BW'(`SRP_RP_CYC - 1);
                  end else if (ref_pend_reg) begin
                     cmd_reg <= CMD_REF;
                     busy_reg <= BW'(`SRP_RFC_CYC - 1);
                     state_reg <= ST_REF;
                  end else begin
                     cmd_reg <= CMD_REF;
                     cke_reg <= 1'b0;
                     busy_reg <= BW'(`SRP_RAS_CYC - 1);
                     state_reg <= ST_SR;
                  end
               end else if (pd_req && quiet) begin
                  // gate low with nop enters power-down
                  cke_reg <= 1'b0;
                  state_reg <= ST_PD;
               end else if (susp_req) begin
                  // suspend next internal edge while held
                  cke_reg <= 1'b0;
               end
            end
            ST_REF: begin
               // nops until refresh cycle time is over
               if (busy_reg == '0) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_SR: begin
               // gate held low, clock may stop
               cke_reg <= 1'b0;
               clk_run_reg <= 1'b0;
               // leave only after row active time
               if ((busy_reg == '0) && !sr_req) begin
                  clk_run_reg <= 1'b1;
                  busy_reg <= BW'(`SRP_CLK_STABLE_CYC - 1);
                  state_reg <= ST_SR_CLK;
               end
            end
            ST_SR_CLK: begin
               // clock runs stable before gate rises
               if (busy_reg == '0) begin
                  cke_reg <= 1'b1;
                  busy_reg <= BW'(`SRP_XSR_CYC - 1);
                  state_reg <= ST_XSR;
               end
            end
            ST_XSR: begin
               if (busy_reg == '0) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_PD: begin
               cke_reg <= 1'b0;
               // exit edge carries nop with gate high
               if (ref_pend_reg || !pd_req) begin
                  cke_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************
   // open bank tracking
   // ****************************************************
   // auto precharge is not followed: bank stays marked open
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         open_reg <= '0;
      end else if (cmd_reg == CMD_ACT) begin
         open_reg[ba_reg] <= 1'b1;
      end else if (cmd_reg == CMD_PRE) begin
         // all banks or the addressed one
         if (addr_reg[`SRP_PRE_SEL_BIT]) begin
            open_reg <= '0;
         end else begin
            open_reg[ba_reg] <= 1'b0;
         end
      end
   end

   // ****************************************************
   // user handshake and status
   // ****************************************************
   // ready only with no wait and nothing owed
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= (state_reg == ST_IDLE) && !take && (busy_reg == '0) && !ref_pend_reg
            && !iv_done && !sr_req && !pd_req && !susp_req && (cmd_reg == CMD_NOP);
      end
   end

   // mode flags
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sr_st_reg <= 1'b0;
         pd_st_reg <= 1'b0;
         pd_act_reg <= 1'b0;
      end else begin
         sr_st_reg <= (state_reg == ST_SR) || (state_reg == ST_SR_CLK);
         pd_st_reg <= (state_reg == ST_PD);
         pd_act_reg <= (state_reg == ST_PD) && (open_reg != '0);
      end
   end

   assign usr_ready = ready_reg;
   assign sd_clk_run = clk_run_reg;
   assign sd_cke = cke_reg;
   assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_reg;
   assign sd_addr = addr_reg;
   assign sd_ba = ba_reg;
   assign st_self_refresh = sr_st_reg;
   assign st_power_down = pd_st_reg;
   assign st_pd_active = pd_act_reg;

   // ****************************************************
   // checks
   // ****************************************************
   logic [BW-1:0] since_ref_reg; // cycles after last refresh
   logic [BW-1:0] since_pre_reg; // cycles after last precharge
   logic [BW-1:0] low_reg; // cycles since gate went low, in any state

   // saturating distance counters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         since_ref_reg <= '1;
         since_pre_reg <= '1;
         low_reg <= '0;
      end else begin
         since_ref_reg <= (cmd_reg == CMD_REF) ? '0 : ((since_ref_reg == '1) ? since_ref_reg : since_ref_reg + 1'b1);
         since_pre_reg <= (cmd_reg == CMD_PRE) ? '0 : ((since_pre_reg == '1) ? since_pre_reg : since_pre_reg + 1'b1);
         low_reg <= cke_reg ? '0 : ((low_reg == '1) ? low_reg : low_reg + 1'b1);
      end
   end

   ref_nop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cke_reg && since_ref_reg < BW'(`SRP_RFC_CYC - 1)) |-> (cmd_reg == CMD_NOP))
      else $error("command during refresh cycle time");
   ref_closed_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cmd_reg == CMD_REF) |-> (open_reg == '0))
      else $error("refresh with an open bank");
   ref_trp_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cmd_reg == CMD_REF) |-> (since_pre_reg >= BW'(`SRP_RP_CYC - 1)))
      else $error("refresh before precharge period");
   sr_gate_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_reg == ST_SR) |-> !cke_reg && (cmd_reg == CMD_NOP || cmd_reg == CMD_REF))
      else $error("gate not low in self refresh");
   sr_min_time_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (($past(state_reg) == ST_SR) && (state_reg == ST_SR_CLK)) |-> (low_reg >= BW'(`SRP_RAS_CYC)))
      else $error("self refresh left before row active time");
   sr_stay_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($fell(cke_reg) && cmd_reg == CMD_REF) |-> !cke_reg [*4])
      else $error("self refresh left too early");
   xsr_nops_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(cke_reg) && $past(state_reg) == ST_SR_CLK) |-> (cmd_reg == CMD_NOP) [*2])
      else $error("command inside self refresh exit time");
   ref_served_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(ref_pend_reg) && (state_reg == ST_IDLE || state_reg == ST_PD) && !sr_req)
      |-> ##[1:64] (cmd_reg == CMD_REF))
      else $error("owed refresh not issued");
   pd_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_reg == ST_PD && ref_pend_reg) |=> (cke_reg && cmd_reg == CMD_NOP && state_reg == ST_IDLE))
      else $error("power-down not left for refresh");
endmodule : srp_ctl
`default_nettype wire

//--- srp_dev_model.sv
// behavioural model of the four-bank memory seen by the controller
`timescale 1ns/1ns
`default_nettype none
`include "srp_params.svh"
module srp_dev_model
   import srp_pkg::*;
#(
   parameter int ROW_CYC = 40
) (
   input wire logic sys_clk,
   input wire logic clk_run,
   input wire logic cke,
   input wire logic [3:0] cmd,
   input wire logic [`SRP_ADDR_W-1:0] addr,
   input wire logic [1:0] ba,
   output logic [15:0] err_cnt,
   output logic [15:0] ref_cnt,
   output logic [15:0] int_ref,
   output logic in_sr,
   output logic in_pd,
   output logic pd_act,
   output logic [3:0] open_bk
);
   // ****
   // state
   // ****
   logic cke_q = 1'b0; // gate at last edge
   logic run_q = 1'b0; // clock ran at last edge
   logic [7:0] pre_cyc = 8'hff; // edges since precharge
   logic [7:0] wait_left = 8'h00; // nop-only edges left
   logic [7:0] sr_cyc = 8'h00; // edges in self refresh
   logic [15:0] gap = 16'h0000; // edges since refresh
   logic quiet; // nop or inhibit on the pins
   assign quiet = cmd[3] | (cmd == CMD_NOP);
   // outputs start idle
   initial begin
      err_cnt = 16'h0000;
      ref_cnt = 16'h0000;
      int_ref = 16'h0000;
      in_sr = 1'b0;
      in_pd = 1'b0;
      pd_act = 1'b0;
      open_bk = 4'h0;
   end
   // ****
   // command decode and timing watch
   // ****
   always @(posedge sys_clk) begin
      cke_q <= cke;
      run_q <= clk_run;
      pre_cyc <= (pre_cyc == 8'hff) ? pre_cyc : pre_cyc + 8'h01;
      gap <= gap + 16'h0001;
      if (wait_left != 8'h00) wait_left <= wait_left - 8'h01;
      if (in_sr) begin
         // self clocked: only gate and clock watched, own refreshes
         sr_cyc <= (sr_cyc == 8'hff) ? sr_cyc : sr_cyc + 8'h01;
         gap <= 16'h0000;
         if (sr_cyc[2:0] == 3'h7) int_ref <= int_ref + 16'h0001;
         if (cke) begin
            if (sr_cyc < `SRP_RAS_CYC || !run_q || !clk_run) err_cnt <= err_cnt + 16'h0001;
            in_sr <= 1'b0;
            wait_left <= 8'(`SRP_XSR_CYC - 1);
         end
      end else if (in_pd) begin
         // exit only with nop, no refresh inside
         if (cke) begin
            if (!quiet) err_cnt <= err_cnt + 16'h0001;
            in_pd <= 1'b0;
            pd_act <= 1'b0;
         end
      end else if (!cke && cke_q) begin
         if (cmd == CMD_REF) begin
            // refresh code with gate low, banks shut
            in_sr <= 1'b1;
            sr_cyc <= 8'h00;
            if (open_bk != 4'h0) err_cnt <= err_cnt + 16'h0001;
         end else if (quiet) begin
            // power-down, active with an open row
            in_pd <= 1'b1;
            pd_act <= |open_bk;
         end
      end else if (cke && cke_q) begin
         // an edge after a low gate is suspended
         if (!quiet && wait_left != 8'h00) err_cnt <= err_cnt + 16'h0001;
         case (cmd)
            CMD_ACT: open_bk[ba] <= 1'b1;
            CMD_PRE: begin
               if (addr[`SRP_PRE_SEL_BIT]) open_bk <= 4'h0;
               else open_bk[ba] <= 1'b0;
               pre_cyc <= 8'h01;
            end
            // address ignored, banks shut, spacing kept
            CMD_REF: begin
               if (open_bk != 4'h0 || pre_cyc < `SRP_RP_CYC || gap > ROW_CYC + 24) err_cnt <= err_cnt + 16'h0001;
               ref_cnt <= ref_cnt + 16'h0001;
               gap <= 16'h0000;
               wait_left <= 8'(`SRP_RFC_CYC - 1);
            end
            default: ;
         endcase
      end
   end
endmodule : srp_dev_model
`default_nettype wire

//--- srp_params.svh
// timing counts, field positions and reset values of the refresh and power-down controller
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

// ****************************************************
// clock and device times in ns, and the refresh row count
// ****************************************************
`define SRP_CLK_NS 10
`define SRP_REFRESH_CYCLE_TIME_NS 70
`define SRP_PRECHARGE_PERIOD_NS 20
`define SRP_ROW_ACTIVE_TIME_NS 44
`define SRP_SELF_REFRESH_EXIT_TIME_NS 70
`define SRP_REFRESH_INTERVAL_NS 64000000
`define SRP_REFRESH_ROWS 8192

// ****************************************************
// derived cycle counts (least times round up)
// ****************************************************
`define SRP_RFC_CYC ((`SRP_REFRESH_CYCLE_TIME_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_RP_CYC ((`SRP_PRECHARGE_PERIOD_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_RAS_CYC ((`SRP_ROW_ACTIVE_TIME_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_XSR_RAW ((`SRP_SELF_REFRESH_EXIT_TIME_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_XSR_CYC ((`SRP_XSR_RAW < 2) ? 2 : `SRP_XSR_RAW)
// spacing of single refreshes (longest time rounds down)
`define SRP_ROW_CYC ((`SRP_REFRESH_INTERVAL_NS / `SRP_REFRESH_ROWS) / `SRP_CLK_NS)
// cycles of running clock before gate goes high after self refresh
`define SRP_CLK_STABLE_CYC 4

// ****************************************************
// fields and reset values
// ****************************************************
`define SRP_PRE_SEL_BIT 10
`define SRP_ADDR_W 12
`define SRP_BANKS 4
`define SRP_CKE_RST 1'b0

`endif

//--- srp_pkg.sv
// types of the refresh and power-down controller
`default_nettype none
package srp_pkg;
   // command encoding {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_INH = 4'h8,
      CMD_NOP = 4'h7,
      CMD_ACT = 4'h3,
      CMD_RD = 4'h5,
      CMD_WR = 4'h4,
      CMD_PRE = 4'h2,
      CMD_REF = 4'h1
   } srp_cmd_t;
   // controller states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REF = 3'h1,
      ST_SR = 3'h2,
      ST_SR_CLK = 3'h3,
      ST_XSR = 3'h4,
      ST_PD = 3'h5
   } srp_state_t;
endpackage : srp_pkg
`default_nettype wire

//--- srp_timer.sv
// reloadable down counter with zero flag
`timescale 1ns/1ns
`default_nettype none
module srp_timer #(
   parameter int W = 16
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic done
);
   logic [W-1:0] count_reg; // cycles left

   // ****************************************************
   // counter
   // ****************************************************
   // load wins, otherwise count down to zero and stop
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_val;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   assign done = (count_reg == '0);
endmodule : srp_timer
`default_nettype wire

//--- tb_srp_ctl.sv
// self-checking testbench of the refresh and power-down controller
`timescale 1ns/1ns
`default_nettype none
module tb_srp_ctl;
   import srp_pkg::*;
   localparam int ROW_CYC = 40; // short refresh spacing
   logic sys_clk, nrst, usr_valid, sr_req, pd_req, susp_req, usr_ready;
   srp_cmd_t usr_cmd; // user command
   logic [11:0] usr_addr, sd_addr;
   logic [1:0] usr_ba, sd_ba;
   logic sd_clk_run, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
   logic st_self_refresh, st_power_down, st_pd_active, in_sr, in_pd, pd_act;
   logic [15:0] err_cnt, ref_cnt, int_ref; // model counters
   logic [3:0] open_bk, pins; // open banks, command pins
   int fail_count = 0;
   int check_count = 0;
   assign pins = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   srp_ctl #(.ADDR_W(12), .ROW_CYC(ROW_CYC)) srp_ctl_inst (.sys_clk(sys_clk), .nrst(nrst),
      .usr_valid(usr_valid), .usr_cmd(usr_cmd), .usr_addr(usr_addr), .usr_ba(usr_ba), .usr_ready(usr_ready),
      .sr_req(sr_req), .pd_req(pd_req), .susp_req(susp_req), .sd_clk_run(sd_clk_run), .sd_cke(sd_cke),
      .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_addr(sd_addr),
      .sd_ba(sd_ba), .st_self_refresh(st_self_refresh), .st_power_down(st_power_down),
      .st_pd_active(st_pd_active));
   srp_dev_model #(.ROW_CYC(ROW_CYC)) srp_dev_model_inst (.sys_clk(sys_clk), .clk_run(sd_clk_run),
      .cke(sd_cke), .cmd(pins), .addr(sd_addr), .ba(sd_ba), .err_cnt(err_cnt), .ref_cnt(ref_cnt),
      .int_ref(int_ref), .in_sr(in_sr), .in_pd(in_pd), .pd_act(pd_act), .open_bk(open_bk));
   // ****
   // helpers
   // ****
   // clock of 10 ns
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // compare and count
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : ticks
   // selected status for bounded waits
   function automatic logic pick(input int sel);
      case (sel)
         0: return st_self_refresh;
         default: return st_power_down;
      endcase
   endfunction : pick
   task automatic wait_for(input int sel, input logic lvl);
      int n;
      n = 0;
      while (pick(sel) !== lvl && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check_val("status wait", lvl, pick(sel));
   endtask : wait_for
   // waits for the next refresh seen by the model
   task automatic wait_ref;
      logic [15:0] r;
      int n;
      r = ref_cnt;
      n = 0;
      while (ref_cnt === r && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check_val("refresh issued", 1'b1, ref_cnt !== r);
   endtask : wait_ref
   // one user command, held until taken, then pins checked
   task automatic send(input srp_cmd_t c, input logic [11:0] a, input logic [1:0] b);
      int n;
      n = 0;
      @(posedge sys_clk);
      usr_valid <= 1'b1;
      usr_cmd <= c;
      usr_addr <= a;
      usr_ba <= b;
      do begin
         @(negedge sys_clk);
         n++;
      end while (usr_ready !== 1'b1 && n < 200);
      @(posedge sys_clk);
      usr_valid <= 1'b0;
      @(negedge sys_clk);
      check_val("command pins", c, pins);
      check_val("address pins", a, sd_addr);
      check_val("bank pins", b, sd_ba);
   endtask : send
   // ****
   // scenarios
   // ****
   // open row forces precharge all before refresh
   task automatic t_refresh;
      logic [15:0] r;
      send(CMD_ACT, 12'h123, 2'h1);
      wait_ref();
      check_val("banks after refresh", 4'h0, open_bk);
      r = ref_cnt;
      ticks(4 * ROW_CYC);
      check_val("refresh rate", 1'b1, (ref_cnt - r) >= 16'h0003 && (ref_cnt - r) <= 16'h0005);
   endtask : t_refresh
   // single bank and all bank precharge
   task automatic t_prech;
      wait_ref();
      send(CMD_ACT, 12'h011, 2'h0);
      send(CMD_ACT, 12'h022, 2'h2);
      send(CMD_PRE, 12'h000, 2'h0);
      // model takes the pins one edge later
      @(negedge sys_clk);
      check_val("one bank closed", 4'h4, open_bk);
      send(CMD_PRE, 12'h400, 2'h3);
      @(negedge sys_clk);
      check_val("all banks closed", 4'h0, open_bk);
   endtask : t_prech
   // active power-down left for a refresh
   task automatic t_pd;
      wait_ref();
      send(CMD_ACT, 12'h055, 2'h2);
      @(posedge sys_clk);
      pd_req <= 1'b1;
      wait_for(1, 1'b1);
      check_val("active power-down", 3'h7, {st_pd_active, pd_act, in_pd});
      wait_ref();
      @(posedge sys_clk);
      pd_req <= 1'b0;
      wait_for(1, 1'b0);
      ticks(2);
      check_val("power-down left", 1'b0, in_pd);
   endtask : t_pd
   // self refresh stay and exit
   task automatic t_self;
      logic [15:0] r;
      logic [15:0] i;
      sr_req <= 1'b1;
      wait_for(0, 1'b1);
      ticks(3);
      check_val("self refresh entry", 2'h1, {sd_cke, in_sr});
      r = ref_cnt;
      i = int_ref;
      ticks(30);
      check_val("clock stopped", 1'b0, sd_clk_run);
      check_val("no outside refresh", r, ref_cnt);
      check_val("inner refresh", 1'b1, int_ref !== i);
      sr_req <= 1'b0;
      wait_for(0, 1'b0);
      check_val("self refresh exit", 2'h2, {sd_cke, in_sr});
      wait_ref();
   endtask : t_self
   // gate low while idle, then back
   task automatic t_susp;
      @(posedge sys_clk);
      susp_req <= 1'b1;
      // refresh cycle time still running, gate drops once idle
      ticks(10);
      check_val("gate dropped", 1'b0, sd_cke);
      susp_req <= 1'b0;
      ticks(3);
      check_val("gate restored", 2'h2, {sd_cke, in_pd});
   endtask : t_susp
   // ****
   // run control
   // ****
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // watchdog well beyond the expected run
   initial begin
      repeat (8000) @(posedge sys_clk);
      fail_count++;
      finish_test();
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      usr_valid = 1'b0;
      usr_cmd = CMD_NOP;
      usr_addr = 12'h000;
      usr_ba = 2'h0;
      sr_req = 1'b0;
      pd_req = 1'b0;
      susp_req = 1'b0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      check_val("reset pins", 5'h08, {sd_cke, pins});
      @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check_val("first pins", 5'h17, {sd_cke, pins});
      // a refresh is owed at once, so ready stays low
      @(negedge sys_clk);
      check_val("refresh at start", 5'h11, {sd_cke, pins});
      check_val("ready after reset", 1'b0, usr_ready);
      t_refresh();
      t_prech();
      t_pd();
      t_self();
      t_susp();
      ticks(20);
      check_val("timing faults", 16'h0000, err_cnt);
      finish_test();
   end
endmodule : tb_srp_ctl
`default_nettype wire
